// File: include/nibble_add_pkg.sv
// Constants, opcode codes and decode helpers for the nibble add unit.
// Assumes a 16-bit program word and a 128 x 4 data memory holding the scratch registers.
package nibble_add_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int INSTR_W = 16;
  localparam int NIB_W = 4;
  localparam int ADDR_W = 7;
  localparam int RAM_DEPTH = 128;
  localparam int WIDX_W = 4;
  localparam int SUM_W = NIB_W + 1;
  localparam int MEM_OP_W = 9;
  localparam int IMM_OP_W = 8;

  // ==========================================================================
  // Field positions in the program word
  localparam int MEM_OP_LSB = 7;
  localparam int IMM_OP_LSB = 8;
  localparam int IMM_LSB = 4;
  localparam int WIDX_LSB = 0;
  localparam int ADDR_LSB = 0;
  localparam int CARRY_POS = 4;

  // ==========================================================================
  // Opcode codes, memory forms (upper nine bits)
  localparam logic [MEM_OP_W-1:0] OPC_ADD_M = 9'h060;
  localparam logic [MEM_OP_W-1:0] OPC_ADDR_M = 9'h032;
  localparam logic [MEM_OP_W-1:0] OPC_ADU_M = 9'h050;
  localparam logic [MEM_OP_W-1:0] OPC_SUM_CARRY_PRESERVED_WRITEBACK_M = 9'h052;

  // Opcode codes, immediate forms (upper eight bits)
  localparam logic [IMM_OP_W-1:0] OPC_ADD_I = 8'h1C;
  localparam logic [IMM_OP_W-1:0] OPC_ADDR_I = 8'h1D;
  localparam logic [IMM_OP_W-1:0] OPC_SUM_WITH_CARRY_WRITEBACK_I = 8'h0D;
  localparam logic [IMM_OP_W-1:0] OPC_ADU_I = 8'h2C;
  localparam logic [IMM_OP_W-1:0] OPC_SUM_CARRY_PRESERVED_WRITEBACK_I = 8'h2D;

  // ==========================================================================
  // Placement of the scratch registers and reset values
  localparam logic [ADDR_W-1:0] WR_BASE = 7'h00;
  localparam logic [NIB_W-1:0] ACC_RST = 4'h0;
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  localparam logic CARRY_RST = 1'b0;
  localparam logic ZERO_RST = 1'b0;

  // ==========================================================================
  // Operation kinds
  typedef enum logic [3:0] {
    OP_NONE,
    OP_ADD_M,
    OP_ADDR_M,
    OP_ADU_M,
    OP_SUM_CARRY_PRESERVED_WRITEBACK_M,
    OP_ADD_I,
    OP_ADDR_I,
    OP_SUM_WITH_CARRY_WRITEBACK_I,
    OP_ADU_I,
    OP_SUM_CARRY_PRESERVED_WRITEBACK_I
  } op_t;

  // Decodes a program word into an operation kind.
  function automatic op_t decode_op(input logic [INSTR_W-1:0] w);
    logic [MEM_OP_W-1:0] mo;
    logic [IMM_OP_W-1:0] io;
    op_t r;
    mo = w[INSTR_W-1:MEM_OP_LSB];
    io = w[INSTR_W-1:IMM_OP_LSB];
    r = OP_NONE;
    if (mo == OPC_ADD_M) r = OP_ADD_M;
    else if (mo == OPC_ADDR_M) r = OP_ADDR_M;
    else if (mo == OPC_ADU_M) r = OP_ADU_M;
    else if (mo == OPC_SUM_CARRY_PRESERVED_WRITEBACK_M) r = OP_SUM_CARRY_PRESERVED_WRITEBACK_M;
    else if (io == OPC_ADD_I) r = OP_ADD_I;
    else if (io == OPC_ADDR_I) r = OP_ADDR_I;
    else if (io == OPC_SUM_WITH_CARRY_WRITEBACK_I) r = OP_SUM_WITH_CARRY_WRITEBACK_I;
    else if (io == OPC_ADU_I) r = OP_ADU_I;
    else if (io == OPC_SUM_CARRY_PRESERVED_WRITEBACK_I) r = OP_SUM_CARRY_PRESERVED_WRITEBACK_I;
    return r;
  endfunction : decode_op

  // True for the immediate forms.
  function automatic logic op_is_imm(input op_t op);
    return (op == OP_ADD_I) || (op == OP_ADDR_I) || (op == OP_SUM_WITH_CARRY_WRITEBACK_I) ||
           (op == OP_ADU_I) || (op == OP_SUM_CARRY_PRESERVED_WRITEBACK_I);
  endfunction : op_is_imm

  // True where the result also goes back to the source location.
  function automatic logic op_writes_back(input op_t op);
    return (op == OP_ADDR_M) || (op == OP_SUM_CARRY_PRESERVED_WRITEBACK_M) || (op == OP_ADDR_I) ||
           (op == OP_SUM_WITH_CARRY_WRITEBACK_I) || (op == OP_SUM_CARRY_PRESERVED_WRITEBACK_I);
  endfunction : op_writes_back

  // True where the carry bit is left as it was.
  function automatic logic op_keeps_carry(input op_t op);
    return (op == OP_ADU_M) || (op == OP_SUM_CARRY_PRESERVED_WRITEBACK_M) || (op == OP_ADU_I) || (op == OP_SUM_CARRY_PRESERVED_WRITEBACK_I);
  endfunction : op_keeps_carry

endpackage : nibble_add_pkg

// File: design/nibble_ram.sv
// Data memory of 128 nibbles with one write port and one registered read port.
// Assumes one clock; contents clear on reset; a read of a location written on the same edge sees the old value.
`timescale 1ns/1ps
module nibble_ram
  import nibble_add_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Write port
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [NIB_W-1:0] wdata,
  // Read port
  input wire logic [ADDR_W-1:0] raddr,
  output logic [NIB_W-1:0] rdata
);

  // ==========================================================================
  // Storage
  logic [NIB_W-1:0] mem_q [RAM_DEPTH];

  // Cleared on reset so that every add starts from known operands.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < RAM_DEPTH; i++) begin
        mem_q[i] <= NIB_ZERO;
      end
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // ==========================================================================
  // Registered read
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= NIB_ZERO;
    end else begin
      rdata <= mem_q[raddr];
    end
  end

endmodule : nibble_ram

// File: design/nibble_add_unit.sv
// Decode and execution of the nibble add instruction group, with accumulator, flags and data memory.
// Assumes the program word arrives with a valid and ready handshake on the core clock.
`timescale 1ns/1ps

// Contract
// RL1: Memory forms take the low seven word bits as the operand's memory address.
// RL2: Plain memory add loads accumulator with memory plus accumulator, updates both flags.
// RL3: Memory add with writeback stores the sum in accumulator and memory, both flags.
// RL4: Carry-kept memory add with writeback stores sum in both, updates zero only.
// RL5: Carry-kept memory add loads accumulator only, updates zero, keeps carry.
// RL6: Plain immediate add loads accumulator with scratch register plus immediate, both flags.
// RL7: Immediate add with writeback stores sum in accumulator and scratch register, both flags.
// RL8: Immediate add with carry in sums register, immediate, carry; writes both; both flags.
// RL9: Carry-kept immediate add loads accumulator only, updates zero, keeps carry.
// RL10: Carry-kept immediate add with writeback writes both places, updates zero only.
// RL11: Immediate forms take bits seven to four as immediate, three to zero as index.
// RL12: Each add, with writeback and flags, completes within one machine cycle; the unit takes two mclk cycles, accept then execute.
// RL13: Carry is the carry out of bit three; zero is set when the result is zero.
module nibble_add_unit
  import nibble_add_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Program word from the decoder
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  output logic instr_ready,
  output logic done,
  // Direct loads from the rest of the core
  input wire logic acc_wr,
  input wire logic [NIB_W-1:0] acc_wdata,
  input wire logic carry_wr,
  input wire logic carry_wdata,
  // Architectural state
  output logic [NIB_W-1:0] acc,
  output logic carry_bit,
  output logic zero_bit,
  // Memory observation
  input wire logic [ADDR_W-1:0] peek_addr,
  output logic [NIB_W-1:0] peek_data
);

  // ==========================================================================
  // Declarations
  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } state_t;

  state_t state_q;
  state_t state_d;
  op_t op_q;
  op_t op_d;
  logic [ADDR_W-1:0] dst_q;
  logic [ADDR_W-1:0] dst_d;
  logic [NIB_W-1:0] imm_q;
  logic [NIB_W-1:0] imm_d;
  logic [NIB_W-1:0] acc_q;
  logic [NIB_W-1:0] acc_d;
  logic carry_q;
  logic carry_d;
  logic zero_q;
  logic zero_d;
  logic done_q;
  logic done_d;

  op_t op_in;
  logic take;
  logic [ADDR_W-1:0] src_addr;
  logic [ADDR_W-1:0] ram_raddr;
  logic [NIB_W-1:0] ram_rdata;
  logic ram_we;
  logic [NIB_W-1:0] opnd_b;
  logic cin;
  logic [SUM_W-1:0] sum;
  logic [NIB_W-1:0] result;

  // ==========================================================================
  // Decode of the incoming word
  always_comb begin
    op_in = decode_op(instr_word);
    take = (state_q == ST_IDLE) && instr_valid && (op_in != OP_NONE);
    if (op_is_imm(op_in)) begin
      src_addr = WR_BASE + {{(ADDR_W-WIDX_W){1'b0}}, instr_word[WIDX_LSB +: WIDX_W]}; // see RL11
    end else begin
      src_addr = instr_word[ADDR_LSB +: ADDR_W]; // see RL1
    end
    ram_raddr = take ? src_addr : peek_addr;
  end

  assign instr_ready = (state_q == ST_IDLE);
  assign done = done_q;
  assign acc = acc_q;
  assign carry_bit = carry_q;
  assign zero_bit = zero_q;
  assign peek_data = ram_rdata;

  // ==========================================================================
  // Adder
  always_comb begin
    if (op_is_imm(op_q)) begin
      opnd_b = imm_q; // see RL6
    end else begin
      opnd_b = acc_q; // see RL2
    end
    cin = (op_q == OP_SUM_WITH_CARRY_WRITEBACK_I) ? carry_q : 1'b0; // see RL8
    sum = SUM_W'(ram_rdata) + SUM_W'(opnd_b) + SUM_W'(cin);
    result = sum[NIB_W-1:0];
  end

  // ==========================================================================
  // Sequencer and state update
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    dst_d = dst_q;
    imm_d = imm_q;
    acc_d = acc_q;
    carry_d = carry_q;
    zero_d = zero_q;
    done_d = 1'b0;
    ram_we = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (acc_wr) begin
          acc_d = acc_wdata;
        end
        if (carry_wr) begin
          carry_d = carry_wdata;
        end
        if (take) begin
          op_d = op_in;
          dst_d = src_addr; // see RL1
          imm_d = instr_word[IMM_LSB +: NIB_W]; // see RL11
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        acc_d = result; // see RL2
        zero_d = (result == NIB_ZERO); // see RL13
        if (!op_keeps_carry(op_q)) begin // see RL4 RL5 RL9 RL10
          carry_d = sum[CARRY_POS]; // see RL13
        end
        ram_we = op_writes_back(op_q); // see RL3 RL4 RL7 RL10
        done_d = 1'b1; // see RL12
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      dst_q <= WR_BASE;
      imm_q <= NIB_ZERO;
      acc_q <= ACC_RST;
      carry_q <= CARRY_RST;
      zero_q <= ZERO_RST;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      dst_q <= dst_d;
      imm_q <= imm_d;
      acc_q <= acc_d;
      carry_q <= carry_d;
      zero_q <= zero_d;
      done_q <= done_d;
    end
  end

  // ==========================================================================
  // Data memory with the scratch registers at its base
  nibble_ram u_ram (
    .mclk(mclk),
    .rstn(rstn),
    .we(ram_we),
    .waddr(dst_q),
    .wdata(result),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

endmodule : nibble_add_unit

// File: bench/nibble_add_unit_chk.sv
// Port checker of the nibble add unit.
// Assumes one clock domain, mclk, with rstn active low.
`timescale 1ns/1ps
module nibble_add_chk
  import nibble_add_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Program word
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic done,
  // Direct loads
  input wire logic acc_wr,
  input wire logic [NIB_W-1:0] acc_wdata,
  input wire logic carry_wr,
  input wire logic carry_wdata,
  // State
  input wire logic [NIB_W-1:0] acc,
  input wire logic carry_bit,
  input wire logic zero_bit,
  input wire logic [ADDR_W-1:0] peek_addr,
  input wire logic [NIB_W-1:0] peek_data
);
  // ==========================================================================
  // Decode of accepted words
  logic take;
  logic keep;
  assign take = instr_valid && instr_ready && ((instr_word[15:7] inside {OPC_ADD_M, OPC_ADDR_M, OPC_ADU_M, OPC_SUM_CARRY_PRESERVED_WRITEBACK_M})
    || (instr_word[15:8] inside {OPC_ADD_I, OPC_ADDR_I, OPC_SUM_WITH_CARRY_WRITEBACK_I, OPC_ADU_I, OPC_SUM_CARRY_PRESERVED_WRITEBACK_I}));
  assign keep = (instr_word[15:7] inside {OPC_ADU_M, OPC_SUM_CARRY_PRESERVED_WRITEBACK_M}) || (instr_word[15:8] inside {OPC_ADU_I, OPC_SUM_CARRY_PRESERVED_WRITEBACK_I});

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_exec;
    !instr_ready ##1 (done && instr_ready);
  endsequence
  a_take_exec: assert property (take |=> s_exec)
    else $error("add not finished in two cycles");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_ready_back: assert property (!instr_ready |-> ##1 done)
    else $error("execute cycle without done");
  a_zero_flag: assert property (done |-> zero_bit == (acc == NIB_ZERO))
    else $error("zero flag wrong");
  a_carry_kept: assert property (take && keep && !carry_wr |=> ##1 carry_bit == $past(carry_bit, 2))
    else $error("carry changed by carry-kept add");
  a_junk_drop: assert property (instr_valid && instr_ready && !take && !acc_wr && !carry_wr
    |=> !done && $stable(acc) && $stable(carry_bit))
    else $error("unknown word acted on");
  a_idle_load: assert property (acc_wr && instr_ready && !take |=> acc == $past(acc_wdata))
    else $error("acc load lost");
  a_carry_load: assert property (carry_wr && instr_ready && !take |=> carry_bit == $past(carry_wdata))
    else $error("carry load lost");
  a_state_hold: assert property (instr_ready && !acc_wr && !carry_wr
    |=> $stable(acc) && $stable(carry_bit) && $stable(zero_bit))
    else $error("state changed while idle");
endmodule : nibble_add_chk

bind nibble_add_unit nibble_add_chk chk (.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready), .done(done), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
  .carry_wr(carry_wr), .carry_wdata(carry_wdata), .acc(acc), .carry_bit(carry_bit), .zero_bit(zero_bit),
  .peek_addr(peek_addr), .peek_data(peek_data));

// File: bench/tb_top.sv
// Self-checking bench of the nibble add unit.
// Assumes the unit alone, driven at rising mclk edges.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t mismatch", $time); end end
module tb_top
  import nibble_add_pkg::*;
;
  // ==========================================================================
  // Signals and table
  typedef struct {logic [15:0] w; logic [3:0] a; logic c; logic [3:0] f;} row_t;
  logic mclk = 1'b0, rstn = 1'b0, instr_valid = 1'b0, acc_wr = 1'b0, carry_wr = 1'b0, carry_wdata = 1'b0;
  logic [INSTR_W-1:0] instr_word = 16'h0000;
  logic [NIB_W-1:0] acc_wdata = 4'h0, acc, peek_data;
  logic [ADDR_W-1:0] peek_addr = 7'h00;
  logic instr_ready, done, carry_bit, zero_bit;
  logic [3:0] m [128];
  int mismatches = 0, num_checks = 0, cyc = 0;
  // Flags are imm, writeback, keep carry, carry in.
  row_t rows [9] = '{
    '{{OPC_ADD_M, 7'h03}, 4'h9, 1'b1, 4'h0},
    '{{OPC_ADDR_M, 7'h7F}, 4'h7, 1'b0, 4'h4},
    '{{OPC_ADU_M, 7'h03}, 4'hF, 1'b1, 4'h2},
    '{{OPC_SUM_CARRY_PRESERVED_WRITEBACK_M, 7'h7F}, 4'h9, 1'b0, 4'h6},
    '{{OPC_ADD_I, 8'hF2}, 4'h3, 1'b1, 4'h8},
    '{{OPC_ADDR_I, 8'h1E}, 4'h0, 1'b1, 4'hC},
    '{{OPC_SUM_WITH_CARRY_WRITEBACK_I, 8'hFE}, 4'h5, 1'b1, 4'hD},
    '{{OPC_ADU_I, 8'h82}, 4'h6, 1'b0, 4'hA},
    '{{OPC_SUM_CARRY_PRESERVED_WRITEBACK_I, 8'hFE}, 4'hA, 1'b1, 4'hE}
  };

  nibble_add_unit dut (.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .done(done), .acc_wr(acc_wr), .acc_wdata(acc_wdata), .carry_wr(carry_wr),
    .carry_wdata(carry_wdata), .acc(acc), .carry_bit(carry_bit), .zero_bit(zero_bit), .peek_addr(peek_addr),
    .peek_data(peek_data));

  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task automatic step(input row_t r);
    logic [6:0] ad;
    logic [4:0] s;
    ad = r.f[3] ? WR_BASE + {3'h0, r.w[3:0]} : r.w[6:0];
    s = {1'b0, m[ad]} + {1'b0, r.f[3] ? r.w[7:4] : r.a} + {4'h0, r.f[0] & r.c};
    @(posedge mclk);
    acc_wr <= 1'b1;
    acc_wdata <= r.a;
    carry_wr <= 1'b1;
    carry_wdata <= r.c;
    peek_addr <= ad;
    @(posedge mclk);
    acc_wr <= 1'b0;
    carry_wr <= 1'b0;
    instr_valid <= 1'b1;
    instr_word <= r.w;
    @(posedge mclk);
    instr_valid <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK(done, 1'b1)
    `CHK(acc, s[3:0])
    `CHK(carry_bit, r.f[1] ? r.c : s[4])
    `CHK(zero_bit, s[3:0] == 4'h0)
    if (r.f[2]) m[ad] = s[3:0];
    @(posedge mclk);
    #1;
    `CHK(peek_data, m[ad])
  endtask : step

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    for (int j = 0; j < 128; j++) begin
      @(posedge mclk);
      peek_addr <= j[6:0];
      @(posedge mclk);
      #1;
      `CHK(peek_data, 4'h0)
      m[j] = 4'h0;
    end
    $display("test start_state done");
    foreach (rows[i]) step(rows[i]);
    $display("test table done");
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= {OPC_ADDR_I, 8'h35};
    @(posedge mclk);
    instr_word <= {OPC_ADD_I, 8'h45};
    repeat (2) @(posedge mclk);
    instr_valid <= 1'b0;
    @(posedge mclk);
    #1;
    m[5] = m[5] + 4'h3;
    `CHK(acc, m[5] + 4'h4)
    $display("test back_to_back done");
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= 16'hFFFF;
    repeat (3) @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    `CHK(done, 1'b0)
    `CHK(acc, m[5] + 4'h4)
    $display("test unknown_word done");
    @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK({acc, carry_bit, zero_bit, done, instr_ready, peek_data}, {4'h0, 4'h1, 4'h0})
    @(posedge mclk);
    rstn <= 1'b1;
    foreach (m[k]) m[k] = 4'h0;
    step(rows[1]);
    $display("test reset done");
    print_verdict();
  end
endmodule : tb_top
